// file: dma_setup_defines.svh
// Register map, field positions and reset values of the two-channel DMA
`ifndef DMA_SETUP_DEFINES_SVH
`define DMA_SETUP_DEFINES_SVH

`define DMA_CTRL0_ADDR   32'h80000C00
`define DMA_SRC0_ADDR    32'h80000C08
`define DMA_DST0_ADDR    32'h80000C10
`define DMA_LEN0_ADDR    32'h80000C18
`define DMA_CTRL1_ADDR   32'h80000C20
`define DMA_SRC1_ADDR    32'h80000C28
`define DMA_DST1_ADDR    32'h80000C30
`define DMA_LEN1_ADDR    32'h80000C38

`define CTRL_SRC_REGION  31
`define CTRL_SRC_FIXED   29
`define CTRL_SRC_CS_HI   28
`define CTRL_SRC_CS_LO   26
`define CTRL_SRC_W_HI    25
`define CTRL_SRC_W_LO    24
`define CTRL_DST_REGION  23
`define CTRL_DST_FIXED   21
`define CTRL_DST_CS_HI   20
`define CTRL_DST_CS_LO   18
`define CTRL_DST_W_HI    17
`define CTRL_DST_W_LO    16
`define CTRL_TC          8
`define CTRL_ERR         7
`define CTRL_ABT         6
`define CTRL_GO          0
`define CTRL_CFG_MASK    32'hBFBF0100

`define PTR_MASK         32'hFFFFFFEF
`define PTR_ADDR_LO      5
`define PTR_ASI_HI       3
`define LEN_TOTAL_HI     15
`define BURST_SHIFT      5

`define RESET_WORD       32'h00000000
`define CS_LINES         6

`endif

// file: dma_setup_pkg.sv
// Types shared by the DMA engine
package dma_setup_pkg;
  typedef enum logic [2:0] {S_IDLE, S_READ, S_PUSH, S_POP, S_WRITE} state_type;
  typedef logic [1:0] width_type;
endpackage

// file: byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush
`timescale 1ns/1ns
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = store[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end else begin
      if (push) begin
        next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage carries no reset; only the pointers define content
  always_ff @(posedge clk) begin
    if (push && !flush) begin
      store[wr_ptr] <= in_data;
    end
  end
endmodule

// file: dual_channel_dma_setup.sv
// Two-channel DMA: registers, transfer sequencer and width packing
// Contract
// - Region select bit 0 means external bus, 1 means SDRAM, both ends.
// - Chip-select codes 000..101 assert line 0..5; codes 11x assert none.
// - Width 00 is 64 bit, 01 is 32 bit, 10 is 16 bit, 11 is 8 bit.
// - Source address stays fixed when its I/O bit is 1, else it advances.
// - Destination address stays fixed when its I/O bit is 1, else advances.
// - End-of-process pulses at completion only when its enable bit is 1.
// - Source pointer holds address in 31..5 and space id in 3..0.
// - Destination pointer holds address in 31..5 and space id in 3..0.
// - Addresses and lengths count 32-byte bursts; software keeps alignment.
// - Length register bits 15..0 give the number of bursts to move.
// - Length register bits 31..16 report the bursts still left.
// - Writing go as 1 starts a channel; again while running does nothing.
// - Clearing go during a transfer aborts it and sets the cancel flag.
// - A memory exception stops the channel, error flag set.
// - One channel runs at a time; a start on the other waits its turn.
`timescale 1ns/1ns
`include "dma_setup_defines.svh"
module dual_channel_dma_setup
  import dma_setup_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [31:0] reg_addr,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             mem_req,
  output logic             mem_write,
  output logic      [31:0] mem_addr,
  output logic      [3:0]  mem_space,
  output logic             mem_region,
  output logic      [5:0]  mem_chip_select,
  output logic      [1:0]  mem_width,
  output logic      [63:0] mem_wdata,
  input  wire logic [63:0] mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic        memory_exception,
  output logic             end_of_process_out,
  output logic             transfer_active
);
  localparam int OW = $clog2(FIFO_DEPTH) + 1;
  localparam logic [31:0] CTRL_ADDR [2] = '{`DMA_CTRL0_ADDR, `DMA_CTRL1_ADDR};
  localparam logic [31:0] SRC_ADDR  [2] = '{`DMA_SRC0_ADDR, `DMA_SRC1_ADDR};
  localparam logic [31:0] DST_ADDR  [2] = '{`DMA_DST0_ADDR, `DMA_DST1_ADDR};
  localparam logic [31:0] LEN_ADDR  [2] = '{`DMA_LEN0_ADDR, `DMA_LEN1_ADDR};

  function automatic logic [3:0] width_bytes(input width_type w);
    logic [3:0] n;
    n = 4'h1;
    unique case (w)
      2'b00: n = 4'h8;
      2'b01: n = 4'h4;
      2'b10: n = 4'h2;
      2'b11: n = 4'h1;
    endcase
    return n;
  endfunction

  function automatic logic [5:0] cs_decode(input logic [2:0] code);
    logic [5:0] lines;
    lines = 6'h00;
    if (code[2:1] != 2'b11) begin
      lines[code] = 1'b1;
    end
    return lines;
  endfunction

  logic [31:0] ctrl_cfg [2];
  logic [31:0] src_reg  [2];
  logic [31:0] dst_reg  [2];
  logic [15:0] count_reg [2];
  logic [15:0] remain   [2];
  logic [1:0]  go;
  logic [1:0]  err_flag;
  logic [1:0]  cancel_flag;
  logic [31:0] next_ctrl_cfg [2];
  logic [31:0] next_src_reg  [2];
  logic [31:0] next_dst_reg  [2];
  logic [15:0] next_count_reg [2];
  logic [15:0] next_remain   [2];
  logic [1:0]  next_go;
  logic [1:0]  next_err_flag;
  logic [1:0]  next_cancel_flag;
  logic [31:0] next_reg_rdata;

  state_type   state;
  state_type   next_state;
  logic        ch;
  logic        next_ch;
  logic [31:0] src_ptr;
  logic [31:0] dst_ptr;
  logic [21:0] rd_left;
  logic [21:0] wr_left;
  logic [OW-1:0] occ;
  logic [63:0] beat;
  logic [3:0]  beat_cnt;
  logic [2:0]  lane;
  logic [31:0] next_src_ptr;
  logic [31:0] next_dst_ptr;
  logic [21:0] next_rd_left;
  logic [21:0] next_wr_left;
  logic [OW-1:0] next_occ;
  logic [63:0] next_beat;
  logic [3:0]  next_beat_cnt;
  logic [2:0]  next_lane;
  logic [31:0] next_mem_addr;
  logic [3:0]  next_mem_space;
  logic        next_mem_region;
  logic [5:0]  next_mem_chip_select;
  logic [1:0]  next_mem_width;
  logic        next_eop;

  logic        fifo_flush;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [7:0]  fifo_out_data;
  logic [31:0] cur_cfg;
  logic [31:0] out_cfg;
  logic [3:0]  sbytes;
  logic [3:0]  dbytes;
  logic        start_ch;
  logic        abort;

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .flush     (fifo_flush),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (beat[7:0]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign transfer_active = state != S_IDLE;
  assign mem_req   = (state == S_READ) || (state == S_WRITE);
  assign mem_write = state == S_WRITE;
  assign mem_wdata = beat;
  assign cur_cfg   = ctrl_cfg[ch];
  assign out_cfg   = ctrl_cfg[next_ch];
  assign sbytes    = width_bytes(cur_cfg[`CTRL_SRC_W_HI:`CTRL_SRC_W_LO]);
  assign dbytes    = width_bytes(cur_cfg[`CTRL_DST_W_HI:`CTRL_DST_W_LO]);
  // Go clearing on the running channel; config is frozen meanwhile
  assign abort = transfer_active && reg_write && reg_addr == CTRL_ADDR[ch]
                 && !reg_wdata[`CTRL_GO];

  always_comb begin
    next_ctrl_cfg    = ctrl_cfg;
    next_src_reg     = src_reg;
    next_dst_reg     = dst_reg;
    next_count_reg   = count_reg;
    next_remain      = remain;
    next_go          = go;
    next_err_flag    = err_flag;
    next_cancel_flag = cancel_flag;
    next_reg_rdata   = reg_rdata;
    for (int i = 0; i < 2; i++) begin
      if (reg_write && reg_addr == CTRL_ADDR[i]) begin
        if (!(transfer_active && ch == 1'(i))) begin
          next_ctrl_cfg[i] = reg_wdata & `CTRL_CFG_MASK;
        end
        next_go[i] = reg_wdata[`CTRL_GO];
        if (reg_wdata[`CTRL_ERR]) begin
          next_err_flag[i] = 1'b0;
        end
        if (reg_wdata[`CTRL_ABT]) begin
          next_cancel_flag[i] = 1'b0;
        end
      end
      if (reg_write && reg_addr == SRC_ADDR[i]) begin
        next_src_reg[i] = reg_wdata & `PTR_MASK;
      end
      if (reg_write && reg_addr == DST_ADDR[i]) begin
        next_dst_reg[i] = reg_wdata & `PTR_MASK;
      end
      if (reg_write && reg_addr == LEN_ADDR[i]) begin
        next_count_reg[i] = reg_wdata[`LEN_TOTAL_HI:0];
      end
    end
    if (reg_read) begin
      next_reg_rdata = `RESET_WORD;
      for (int i = 0; i < 2; i++) begin
        if (reg_addr == CTRL_ADDR[i]) begin
          next_reg_rdata = ctrl_cfg[i];
          next_reg_rdata[`CTRL_ERR] = err_flag[i];
          next_reg_rdata[`CTRL_ABT] = cancel_flag[i];
          next_reg_rdata[`CTRL_GO]  = go[i];
        end
        if (reg_addr == SRC_ADDR[i]) begin
          next_reg_rdata = src_reg[i];
        end
        if (reg_addr == DST_ADDR[i]) begin
          next_reg_rdata = dst_reg[i];
        end
        if (reg_addr == LEN_ADDR[i]) begin
          next_reg_rdata = {remain[i], count_reg[i]};
        end
      end
    end

    next_state    = state;
    next_ch       = ch;
    next_src_ptr  = src_ptr;
    next_dst_ptr  = dst_ptr;
    next_rd_left  = rd_left;
    next_wr_left  = wr_left;
    next_occ      = occ;
    next_beat     = beat;
    next_beat_cnt = beat_cnt;
    next_lane     = lane;
    next_eop      = 1'b0;
    fifo_flush     = 1'b0;
    fifo_in_valid  = 1'b0;
    fifo_out_ready = 1'b0;
    start_ch = !(go[0] && next_go[0]);
    unique case (state)
      S_IDLE: begin
        // Lower channel wins when both wait; the other stays queued
        if (go[start_ch] && next_go[start_ch]) begin
          next_ch  = start_ch;
          next_src_ptr = {src_reg[start_ch][31:`PTR_ADDR_LO], 5'h00};
          next_dst_ptr = {dst_reg[start_ch][31:`PTR_ADDR_LO], 5'h00};
          next_rd_left = 22'({count_reg[start_ch], 5'h00});
          next_wr_left = 22'({count_reg[start_ch], 5'h00});
          next_remain[start_ch] = count_reg[start_ch];
          next_occ   = '0;
          next_lane  = 3'h0;
          fifo_flush = 1'b1;
          if (count_reg[start_ch] == 16'h0000) begin
            next_go[start_ch] = 1'b0;
            next_eop = ctrl_cfg[start_ch][`CTRL_TC];
          end else begin
            next_state = S_READ;
          end
        end
      end
      S_READ: begin
        if (mem_ack && memory_exception) begin
          next_err_flag[ch] = 1'b1;
          next_go[ch] = 1'b0;
          next_state  = S_IDLE;
          fifo_flush  = 1'b1;
        end else if (mem_ack) begin
          next_beat     = mem_rdata;
          next_beat_cnt = sbytes;
          next_rd_left  = rd_left - 22'(sbytes);
          if (!cur_cfg[`CTRL_SRC_FIXED]) begin
            next_src_ptr = src_ptr + 32'(sbytes);
          end
          next_state = S_PUSH;
        end
      end
      S_PUSH: begin
        fifo_in_valid = 1'b1;
        if (fifo_in_ready) begin
          next_beat     = {8'h00, beat[63:8]};
          next_beat_cnt = beat_cnt - 4'h1;
          next_occ      = occ + OW'(1);
          if (beat_cnt == 4'h1) begin
            next_state = (next_occ >= OW'(dbytes) || rd_left == '0)
                         ? S_POP : S_READ;
          end
        end
      end
      S_POP: begin
        fifo_out_ready = 1'b1;
        if (fifo_out_valid) begin
          next_beat[{lane, 3'b000} +: 8] = fifo_out_data;
          next_occ  = occ - OW'(1);
          next_lane = lane + 3'h1;
          if (lane == 3'(dbytes - 4'h1)) begin
            next_lane  = 3'h0;
            next_state = S_WRITE;
          end
        end
      end
      S_WRITE: begin
        if (mem_ack && memory_exception) begin
          next_err_flag[ch] = 1'b1;
          next_go[ch] = 1'b0;
          next_state  = S_IDLE;
          fifo_flush  = 1'b1;
        end else if (mem_ack) begin
          next_wr_left = wr_left - 22'(dbytes);
          if (!cur_cfg[`CTRL_DST_FIXED]) begin
            next_dst_ptr = dst_ptr + 32'(dbytes);
          end
          if (next_wr_left[4:0] == 5'h00) begin
            next_remain[ch] = remain[ch] - 16'h0001;
          end
          if (next_wr_left == '0) begin
            next_go[ch] = 1'b0;
            next_state  = S_IDLE;
            next_eop    = cur_cfg[`CTRL_TC];
          end else if (occ >= OW'(dbytes)) begin
            next_state = S_POP;
          end else begin
            next_state = S_READ;
          end
        end
      end
    endcase
    if (abort) begin
      next_cancel_flag[ch] = 1'b1;
      next_go[ch] = 1'b0;
      next_state  = S_IDLE;
      next_eop    = 1'b0;
      fifo_flush  = 1'b1;
    end

    next_mem_addr        = mem_addr;
    next_mem_space       = mem_space;
    next_mem_region      = mem_region;
    next_mem_chip_select = mem_chip_select;
    next_mem_width       = mem_width;
    if (next_state == S_WRITE) begin
      next_mem_addr   = next_dst_ptr;
      next_mem_space  = dst_reg[next_ch][`PTR_ASI_HI:0];
      next_mem_region = out_cfg[`CTRL_DST_REGION];
      next_mem_chip_select =
        cs_decode(out_cfg[`CTRL_DST_CS_HI:`CTRL_DST_CS_LO]);
      next_mem_width  = out_cfg[`CTRL_DST_W_HI:`CTRL_DST_W_LO];
    end else if (next_state == S_READ) begin
      next_mem_addr   = next_src_ptr;
      next_mem_space  = src_reg[next_ch][`PTR_ASI_HI:0];
      next_mem_region = out_cfg[`CTRL_SRC_REGION];
      next_mem_chip_select =
        cs_decode(out_cfg[`CTRL_SRC_CS_HI:`CTRL_SRC_CS_LO]);
      next_mem_width  = out_cfg[`CTRL_SRC_W_HI:`CTRL_SRC_W_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 2; i++) begin
        ctrl_cfg[i]  <= `RESET_WORD;
        src_reg[i]   <= `RESET_WORD;
        dst_reg[i]   <= `RESET_WORD;
        count_reg[i] <= 16'h0000;
        remain[i]    <= 16'h0000;
      end
      go          <= 2'b00;
      err_flag    <= 2'b00;
      cancel_flag <= 2'b00;
      reg_rdata   <= `RESET_WORD;
      state       <= S_IDLE;
      ch          <= 1'b0;
      src_ptr     <= `RESET_WORD;
      dst_ptr     <= `RESET_WORD;
      rd_left     <= '0;
      wr_left     <= '0;
      occ         <= '0;
      beat        <= 64'h0000000000000000;
      beat_cnt    <= 4'h0;
      lane        <= 3'h0;
      mem_addr    <= `RESET_WORD;
      mem_space   <= 4'h0;
      mem_region  <= 1'b0;
      mem_chip_select    <= 6'h00;
      mem_width          <= 2'b00;
      end_of_process_out <= 1'b0;
    end else begin
      ctrl_cfg    <= next_ctrl_cfg;
      src_reg     <= next_src_reg;
      dst_reg     <= next_dst_reg;
      count_reg   <= next_count_reg;
      remain      <= next_remain;
      go          <= next_go;
      err_flag    <= next_err_flag;
      cancel_flag <= next_cancel_flag;
      reg_rdata   <= next_reg_rdata;
      state       <= next_state;
      ch          <= next_ch;
      src_ptr     <= next_src_ptr;
      dst_ptr     <= next_dst_ptr;
      rd_left     <= next_rd_left;
      wr_left     <= next_wr_left;
      occ         <= next_occ;
      beat        <= next_beat;
      beat_cnt    <= next_beat_cnt;
      lane        <= next_lane;
      mem_addr    <= next_mem_addr;
      mem_space   <= next_mem_space;
      mem_region  <= next_mem_region;
      mem_chip_select    <= next_mem_chip_select;
      mem_width          <= next_mem_width;
      end_of_process_out <= next_eop;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic cur_abt;
  logic cur_err;
  assign cur_abt = cancel_flag[ch];
  assign cur_err = err_flag[ch];

  property p_region_select;
    mem_req |-> mem_region == (mem_write ? cur_cfg[`CTRL_DST_REGION]
                                         : cur_cfg[`CTRL_SRC_REGION]);
  endproperty
  a_region_select: assert property (p_region_select)
    else $error("region select does not follow control");

  property p_cs_decode;
    mem_req && !mem_write |-> $onehot0(mem_chip_select) &&
      ((cur_cfg[`CTRL_SRC_CS_HI:`CTRL_SRC_CS_HI-1] == 2'b11) ==
       (mem_chip_select == 6'h00));
  endproperty
  a_cs_decode: assert property (p_cs_decode)
    else $error("source chip select decode wrong");

  property p_dst_width;
    mem_req && mem_write |->
      mem_width == cur_cfg[`CTRL_DST_W_HI:`CTRL_DST_W_LO];
  endproperty
  a_dst_width: assert property (p_dst_width)
    else $error("destination width wrong");

  property p_src_step;
    state == S_READ && mem_ack && !memory_exception && !abort |=>
      src_ptr == $past(src_ptr) +
        ($past(cur_cfg[`CTRL_SRC_FIXED]) ? 32'h0 : 32'($past(sbytes)));
  endproperty
  a_src_step: assert property (p_src_step)
    else $error("source address step wrong");

  property p_dst_step;
    state == S_WRITE && mem_ack && !memory_exception && !abort |=>
      dst_ptr == $past(dst_ptr) +
        ($past(cur_cfg[`CTRL_DST_FIXED]) ? 32'h0 : 32'($past(dbytes)));
  endproperty
  a_dst_step: assert property (p_dst_step)
    else $error("destination address step wrong");

  property p_eop_gated;
    (!ctrl_cfg[0][`CTRL_TC] && !ctrl_cfg[1][`CTRL_TC]) ##1 1'b1
      |-> !end_of_process_out;
  endproperty
  a_eop_gated: assert property (p_eop_gated)
    else $error("end of process driven while disabled");

  property p_remain_load;
    state == S_IDLE && next_state == S_READ |=>
      remain[ch] == count_reg[ch];
  endproperty
  a_remain_load: assert property (p_remain_load)
    else $error("remaining count not loaded");

  property p_restart_ignored;
    transfer_active && reg_write && reg_addr == CTRL_ADDR[ch] &&
      reg_wdata[`CTRL_GO] && !reg_wdata[`CTRL_ABT] |=> $stable(cur_abt);
  endproperty
  a_restart_ignored: assert property (p_restart_ignored)
    else $error("restart disturbed running channel");

  property p_abort;
    abort |=> state == S_IDLE && cur_abt && !go[ch];
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort not taken");

  property p_error_stop;
    mem_req && mem_ack && memory_exception |=>
      state == S_IDLE && cur_err && !mem_req;
  endproperty
  a_error_stop: assert property (p_error_stop)
    else $error("error did not stop channel");

  property p_one_channel;
    transfer_active ##1 transfer_active |-> $stable(ch);
  endproperty
  a_one_channel: assert property (p_one_channel)
    else $error("channel switched mid transfer");

  c_done_eop: cover property (mem_write && mem_ack ##1 end_of_process_out);
  c_abort: cover property (abort);
  c_error: cover property (mem_req && mem_ack && memory_exception);
  c_queued: cover property (transfer_active && go == 2'b11);
endmodule

// file: mem_model.sv
// Far-side memory model answering DMA beats after a set delay
`timescale 1ns/1ns
module mem_model (
  input  wire logic        clk,
  input  wire logic        mem_req,
  input  wire logic        mem_write,
  input  wire logic [31:0] mem_addr,
  input  wire logic        mem_region,
  input  wire logic [5:0]  mem_chip_select,
  input  wire logic [3:0]  mem_space,
  input  wire logic [1:0]  mem_width,
  input  wire logic [63:0] mem_wdata,
  output logic      [63:0] mem_rdata,
  output logic             mem_ack,
  output logic             memory_exception,
  input  wire logic [3:0]  delay,
  input  wire logic        fail
);
  int          wait_n = 0;
  int          writes = 0;
  logic [31:0] last_rd, last_wr;
  logic [63:0] last_data;
  logic [12:0] rd_sel, wr_sel;
  initial mem_rdata = 64'h0;
  initial mem_ack = 1'b0;
  initial memory_exception = 1'b0;
  always @(posedge clk) begin
    if (mem_req && !mem_ack && wait_n < delay) begin
      wait_n <= wait_n + 1;
    end else if (mem_req && !mem_ack) begin
      wait_n <= 0;
      mem_ack <= 1'b1;
      memory_exception <= fail;
      if (mem_write) begin
        writes <= writes + 1;
        last_wr <= mem_addr;
        last_data <= mem_wdata;
        wr_sel <= {mem_space, mem_width, mem_region, mem_chip_select};
      end else begin
        last_rd <= mem_addr;
        rd_sel <= {mem_space, mem_width, mem_region, mem_chip_select};
        mem_rdata <= {2{mem_addr}};
      end
    end else begin
      // A dropped request must not shorten the next wait
      wait_n <= 0;
      mem_ack <= 1'b0;
      memory_exception <= 1'b0;
      // Stale bus: never hold the last word
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// file: tb_top.sv
// Register-level testbench for the two-channel DMA
`timescale 1ns/1ns
`include "dma_setup_defines.svh"
module tb_top;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [31:0] reg_addr = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, mem_addr, d;
  logic [63:0] mem_wdata, mem_rdata;
  logic [5:0]  mem_chip_select;
  logic [3:0]  mem_space;
  logic [3:0]  delay = 4'h0;
  logic [1:0]  mem_width;
  logic        mem_req, mem_write, mem_region, mem_ack, memory_exception;
  logic        end_of_process_out, transfer_active;
  logic        fail = 1'b0;
  int          failures = 0;
  int          checked = 0;
  int          eops = 0;
  dual_channel_dma_setup #(.FIFO_DEPTH(16)) i_dual_channel_dma_setup (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_space(mem_space), .mem_region(mem_region),
    .mem_chip_select(mem_chip_select), .mem_width(mem_width),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .memory_exception(memory_exception),
    .end_of_process_out(end_of_process_out),
    .transfer_active(transfer_active));
  mem_model i_mem_model (
    .clk(clk), .mem_req(mem_req), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_region(mem_region),
    .mem_chip_select(mem_chip_select), .mem_space(mem_space),
    .mem_width(mem_width), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .memory_exception(memory_exception), .delay(delay), .fail(fail));
  always #25 clk = ~clk;
  always @(posedge clk) if (end_of_process_out === 1'b1) eops++;
  task automatic check(input string n, input logic [63:0] s, e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [31:0] a, w);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = w;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
  endtask
  // Extra cycle so either read latency reading holds
  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    @(negedge clk);
    r = reg_rdata;
  endtask
  task automatic go(input logic [31:0] a, c);
    eops = 0;
    i_mem_model.writes = 0;
    wr(a, c);
  endtask
  task automatic settle();
    int n;
    n = 0;
    repeat (3) @(negedge clk);
    while (transfer_active !== 1'b0 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    check("idle", transfer_active, 1'b0);
    repeat (2) @(negedge clk);
  endtask
  task automatic give_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(`DMA_CTRL0_ADDR + 32'(a * 8), d);
      check("reset", d, 32'h0);
    end
    wr(32'h80000C04, 32'hFFFFFFFF);
    rd(32'h80000C04, d);
    check("unmapped", d, 32'h0);
    wr(`DMA_SRC0_ADDR, 32'hFFFFFFFF);
    rd(`DMA_SRC0_ADDR, d);
    check("src ptr", d, 32'hFFFFFFEF);
    wr(`DMA_DST0_ADDR, 32'hFFFFFFFF);
    rd(`DMA_DST0_ADDR, d);
    check("dst ptr", d, 32'hFFFFFFEF);
    wr(`DMA_LEN0_ADDR, 32'hFFFF0001);
    rd(`DMA_LEN0_ADDR, d);
    check("len", d, 32'h00000001);
    wr(`DMA_SRC0_ADDR, 32'h00001005);
    wr(`DMA_DST0_ADDR, 32'h00002000);
    // SDRAM source on line 2, destination with no select, eop on
    go(`DMA_CTRL0_ADDR, 32'h881C0101);
    settle();
    check("eop", eops, 1);
    check("beats", i_mem_model.writes, 4);
    check("rd addr", i_mem_model.last_rd, 32'h00001018);
    check("wr addr", i_mem_model.last_wr, 32'h00002018);
    check("data", i_mem_model.last_data, {2{32'h00001018}});
    check("rd sel", i_mem_model.rd_sel, {4'h5, 2'b00, 1'b1, 6'h04});
    check("wr sel", i_mem_model.wr_sel, {4'h0, 2'b00, 1'b0, 6'h00});
    rd(`DMA_LEN0_ADDR, d);
    check("left", d, 32'h00000001);
    rd(`DMA_CTRL0_ADDR, d);
    check("ctrl", d, 32'h881C0100);
    // Fixed 4-byte source into fixed byte destination, eop off
    wr(`DMA_SRC0_ADDR, 32'h12345660);
    go(`DMA_CTRL0_ADDR, 32'h35230001);
    settle();
    check("no eop", eops, 0);
    check("byte beats", i_mem_model.writes, 32);
    check("fixed rd", i_mem_model.last_rd, 32'h12345660);
    check("fixed wr", i_mem_model.last_wr, 32'h00002000);
    check("last byte", i_mem_model.last_data[7:0], 8'h12);
    check("cs5", i_mem_model.rd_sel, {4'h0, 2'b01, 1'b0, 6'h20});
    check("byte wr", i_mem_model.wr_sel, {4'h0, 2'b11, 1'b0, 6'h01});
    wr(`DMA_LEN0_ADDR, 32'h00000004);
    delay = 4'h8;
    go(`DMA_CTRL0_ADDR, 32'h00000101);
    repeat (20) @(negedge clk);
    wr(`DMA_CTRL0_ADDR, 32'h00000100);
    settle();
    rd(`DMA_CTRL0_ADDR, d);
    check("cancel", d[6], 1'b1);
    check("abort eop", eops, 0);
    wr(`DMA_CTRL0_ADDR, 32'h00000040);
    fail = 1'b1;
    go(`DMA_CTRL0_ADDR, 32'h00000101);
    settle();
    fail = 1'b0;
    rd(`DMA_CTRL0_ADDR, d);
    check("err", {d[7], d[0]}, 2'b10);
    check("err beats", i_mem_model.writes, 0);
    wr(`DMA_CTRL0_ADDR, 32'h00000080);
    delay = 4'h2;
    wr(`DMA_LEN0_ADDR, 32'h00000001);
    wr(`DMA_LEN1_ADDR, 32'h00000001);
    wr(`DMA_SRC1_ADDR, 32'h00003000);
    wr(`DMA_DST1_ADDR, 32'h00004000);
    go(`DMA_CTRL0_ADDR, 32'h00000101);
    // Channel 1 packs half-word reads into double-word writes
    wr(`DMA_CTRL1_ADDR, 32'h02000101);
    wr(`DMA_CTRL0_ADDR, 32'h00000101);
    settle();
    settle();
    check("two eops", eops, 2);
    check("two runs", i_mem_model.writes, 8);
    check("ch1 last", i_mem_model.last_wr, 32'h00004018);
    check("pack", i_mem_model.last_data, 64'h301E301C301A3018);
    check("ch1 rd", i_mem_model.rd_sel, {4'h0, 2'b10, 1'b0, 6'h01});
    give_verdict();
  end
endmodule
